// ===== rtl/aer_regs_pkg.sv
// package: register map, field positions and reset values of the error register bank
package aer_regs_pkg;
	localparam logic [11:0] ofs_uncorr_severity = 12'h10C;
	localparam logic [11:0] ofs_corr_status = 12'h110;
	localparam logic [11:0] ofs_corr_mask = 12'h114;
	localparam logic [11:0] ofs_adv_control = 12'h118;
	localparam logic [11:0] ofs_uncorr_status = 12'h130;
	localparam logic [11:0] ofs_uncorr_mask = 12'h134;
	localparam logic [11:0] ofs_irq_status = 12'h140;
	localparam logic [11:0] ofs_irq_mask = 12'h144;
	localparam logic [11:0] ofs_lock = 12'h148;

	localparam int bit_sev_crc = 19;
	localparam int bit_sev_unsup = 20;
	localparam int bit_rcv_err = 0;
	localparam int bit_bad_pkt = 6;
	localparam int bit_bad_link = 7;
	localparam int bit_rollover = 8;
	localparam int bit_replay_to = 12;
	localparam int bit_advisory = 13;
	localparam int bit_gen_cap = 5;
	localparam int bit_gen_en = 6;
	localparam int bit_chk_cap = 7;
	localparam int bit_chk_en = 8;
	localparam int ptr_w = 5;

	localparam logic [31:0] corr_valid = 32'h0000_31C1;
	localparam logic [31:0] corr_mask_rst = 32'h0000_2000;
	localparam logic [31:0] sev_valid = 32'h0018_0000;
	localparam logic [31:0] unc_valid = 32'h0018_0000;
	localparam logic [2:0] irq_w = 3'h3;
	localparam logic [1:0] htrans_nonseq = 2'h2;
	localparam logic [2:0] hsize_word = 3'h2;
endpackage

// ===== rtl/pcie_advanced_error_regs.sv
// design: advanced error reporting registers of one switch port, AHB-Lite slave
//
// Functional notes
// RL1: unmasked CRC error severity from bit 19
// RL2: unmasked unsupported request severity from bit 20
// RL3: receiver error sets status bit 0
// RL4: bad packet sets status bit 6
// RL5: bad link packet sets status bit 7
// RL6: replay rollover sets status bit 8
// RL7: replay timeout sets status bit 12
// RL8: advisory non-fatal sets status bit 13
// RL9: mask bit 0 blocks receiver error report
// RL10: mask bits 6,7,8,12 block their reports
// RL11: advisory mask resets to one
// RL12: first error pointer in control 4:0
// RL13: generate capable bit, lock-writable, resets one
// RL14: control bit 6 enables CRC generation
// RL15: check capable bit, lock-writable, resets one
// RL16: control bit 8 enables CRC checking
// RL17: uncorrectable mask 19 blocks log and report
// RL18: sticky bits survive non-power-on reset
`timescale 1ns/1ps
module pcie_advanced_error_regs
	import aer_regs_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic power_on_resetn,
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic receiver_error_flag,
	input wire logic bad_packet_flag,
	input wire logic bad_link_packet_flag,
	input wire logic replay_rollover_flag,
	input wire logic replay_timeout_flag,
	input wire logic advisory_nonfatal_flag,
	input wire logic crc_error_event,
	input wire logic unsup_request_event,
	output logic report_correctable,
	output logic report_nonfatal,
	output logic report_fatal,
	output logic crc_generate_enable,
	output logic crc_check_enable,
	output logic irq
);
	logic [31:0] correctable_error_status_reg;
	logic [31:0] correctable_error_mask_reg;
	logic [31:0] severity_reg;
	logic [31:0] uncorrectable_error_status_reg;
	logic [31:0] uncorrectable_error_mask_reg;
	logic [ptr_w-1:0] first_error_pointer_reg;
	logic crc_generate_capable_reg;
	logic crc_check_capable_reg;
	logic gen_en_reg;
	logic chk_en_reg;
	logic lock_open_reg;
	logic [2:0] irq_status_reg;
	logic [2:0] irq_mask_reg;
	logic wr_pend_reg;
	logic [11:0] wr_addr_reg;
	logic [31:0] corr_ev;
	logic [31:0] corr_clr;
	logic [31:0] unc_ev;
	logic [31:0] unc_log;
	logic [31:0] unc_clr;
	logic rd_take;
	logic rep_corr;
	logic rep_nf;
	logic rep_fat;
	logic we_corr_status;
	logic we_corr_mask;
	logic we_severity;
	logic we_unc_status;
	logic we_unc_mask;
	logic we_control;
	logic we_lock;
	logic we_irq_status;
	logic we_irq_mask;
	logic [2:0] irq_set;
	logic [2:0] irq_clr;
	logic [31:0] control_word;
	logic [31:0] rd_word;

	function automatic logic [ptr_w-1:0] lowest_bit(input logic [31:0] v);
		logic [ptr_w-1:0] r;
		r = '0;
		for (int i = 31; i >= 0; i--) begin
			if (v[i]) begin
				r = ptr_w'(i);
			end
		end
		return r;
	endfunction

	function automatic logic wr_hit(input logic pend, input logic [11:0] a, input logic [11:0] o);
		return pend && (a == o);
	endfunction

	// address phase of a whole-word single transfer; other sizes are ignored
	function automatic logic word_req(input logic sel, input logic [1:0] tr, input logic [2:0] sz);
		return sel && (tr == htrans_nonseq) && (sz == hsize_word);
	endfunction

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign rd_take = word_req(hsel, htrans, hsize) && hready && !hwrite;

	// a taken write lands one edge later, when its data phase ends
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
		end else if (hready) begin
			wr_pend_reg <= word_req(hsel, htrans, hsize) && hwrite;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_addr_reg <= '0;
		end else if (hready) begin
			wr_addr_reg <= {haddr[11:2], 2'b00};
		end
	end

	// collect correctable events into their status positions
	always_comb begin
		corr_ev = '0;
		corr_ev[bit_rcv_err] = receiver_error_flag; // see RL3
		corr_ev[bit_bad_pkt] = bad_packet_flag; // see RL4
		corr_ev[bit_bad_link] = bad_link_packet_flag; // see RL5
		corr_ev[bit_rollover] = replay_rollover_flag; // see RL6
		corr_ev[bit_replay_to] = replay_timeout_flag; // see RL7
		corr_ev[bit_advisory] = advisory_nonfatal_flag; // see RL8
	end

	// uncorrectable events at their status positions
	always_comb begin
		unc_ev = '0;
		unc_ev[bit_sev_crc] = crc_error_event;
		unc_ev[bit_sev_unsup] = unsup_request_event;
	end

	// one write strobe per register, high in the data phase of a taken write
	always_comb begin
		we_corr_status = wr_hit(wr_pend_reg, wr_addr_reg, ofs_corr_status);
		we_corr_mask = wr_hit(wr_pend_reg, wr_addr_reg, ofs_corr_mask);
		we_severity = wr_hit(wr_pend_reg, wr_addr_reg, ofs_uncorr_severity);
		we_unc_status = wr_hit(wr_pend_reg, wr_addr_reg, ofs_uncorr_status);
		we_unc_mask = wr_hit(wr_pend_reg, wr_addr_reg, ofs_uncorr_mask);
		we_control = wr_hit(wr_pend_reg, wr_addr_reg, ofs_adv_control);
		we_lock = wr_hit(wr_pend_reg, wr_addr_reg, ofs_lock);
		we_irq_status = wr_hit(wr_pend_reg, wr_addr_reg, ofs_irq_status);
		we_irq_mask = wr_hit(wr_pend_reg, wr_addr_reg, ofs_irq_mask);
	end

	assign corr_clr = we_corr_status ? hwdata : '0;
	assign unc_clr = we_unc_status ? hwdata : '0;
	assign unc_log = unc_ev & ~uncorrectable_error_mask_reg; // see RL17

	// sticky bank: only the power-on reset clears it, event set wins over clear
	always_ff @(posedge hclk or negedge power_on_resetn) begin
		if (!power_on_resetn) begin
			correctable_error_status_reg <= '0; // see RL18
		end else begin
			correctable_error_status_reg <= ((correctable_error_status_reg & ~corr_clr) | corr_ev)
				& corr_valid; // see RL3
		end
	end

	always_ff @(posedge hclk or negedge power_on_resetn) begin
		if (!power_on_resetn) begin
			uncorrectable_error_status_reg <= '0;
		end else begin
			uncorrectable_error_status_reg <= ((uncorrectable_error_status_reg & ~unc_clr) | unc_log)
				& unc_valid; // see RL17
		end
	end

	// pointer captured only while no status bit is pending, held until its bit clears
	always_ff @(posedge hclk or negedge power_on_resetn) begin
		if (!power_on_resetn) begin
			first_error_pointer_reg <= '0;
		end else begin
			if (((uncorrectable_error_status_reg & ~unc_clr) == '0) && (unc_log != '0)) begin
				first_error_pointer_reg <= lowest_bit(unc_log); // see RL12
			end else if (unc_clr[first_error_pointer_reg] && (unc_log == '0)) begin
				first_error_pointer_reg <= '0; // see RL18
			end
		end
	end

	always_ff @(posedge hclk or negedge power_on_resetn) begin
		if (!power_on_resetn) begin
			correctable_error_mask_reg <= corr_mask_rst; // see RL11
		end else if (we_corr_mask) begin
			correctable_error_mask_reg <= hwdata & corr_valid; // see RL10
		end
	end

	always_ff @(posedge hclk or negedge power_on_resetn) begin
		if (!power_on_resetn) begin
			severity_reg <= '0; // see RL2
		end else if (we_severity) begin
			severity_reg <= hwdata & sev_valid; // see RL1
		end
	end

	always_ff @(posedge hclk or negedge power_on_resetn) begin
		if (!power_on_resetn) begin
			uncorrectable_error_mask_reg <= '0;
		end else if (we_unc_mask) begin
			uncorrectable_error_mask_reg <= hwdata & unc_valid; // see RL17
		end
	end

	always_ff @(posedge hclk or negedge power_on_resetn) begin
		if (!power_on_resetn) begin
			gen_en_reg <= 1'b0;
		end else if (we_control) begin
			gen_en_reg <= hwdata[bit_gen_en]; // see RL14
		end
	end

	always_ff @(posedge hclk or negedge power_on_resetn) begin
		if (!power_on_resetn) begin
			chk_en_reg <= 1'b0;
		end else if (we_control) begin
			chk_en_reg <= hwdata[bit_chk_en]; // see RL16
		end
	end

	// capability bits and lock are not sticky
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			crc_generate_capable_reg <= 1'b1;
			crc_check_capable_reg <= 1'b1;
		end else if (we_control && lock_open_reg) begin
			crc_generate_capable_reg <= hwdata[bit_gen_cap]; // see RL13
			crc_check_capable_reg <= hwdata[bit_chk_cap]; // see RL15
		end
	end

	// the locked-write path is open only while this bit is one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lock_open_reg <= 1'b0;
		end else if (we_lock) begin
			lock_open_reg <= hwdata[0];
		end
	end

	assign crc_generate_enable = gen_en_reg; // see RL14
	assign crc_check_enable = chk_en_reg; // see RL16

	// report pulses toward the root complex
	always_comb begin
		rep_corr = |(corr_ev & ~correctable_error_mask_reg & corr_valid); // see RL9
		rep_fat = |(unc_log & severity_reg); // see RL1
		rep_nf = |(unc_log & ~severity_reg); // see RL2
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			report_correctable <= 1'b0;
		end else begin
			report_correctable <= rep_corr; // see RL10
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			report_nonfatal <= 1'b0;
		end else begin
			report_nonfatal <= rep_nf; // see RL2
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			report_fatal <= 1'b0;
		end else begin
			report_fatal <= rep_fat; // see RL1
		end
	end

	// interrupt status: 0 correctable, 1 non-fatal, 2 fatal
	assign irq_set = {rep_fat, rep_nf, rep_corr};
	assign irq_clr = we_irq_status ? hwdata[2:0] : 3'h0;

	// a new report wins over a clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_status_reg <= '0;
		end else begin
			irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_mask_reg <= '0;
		end else if (we_irq_mask) begin
			irq_mask_reg <= hwdata[2:0];
		end
	end

	assign irq = |(irq_status_reg & irq_mask_reg);

	assign control_word = {23'h0, chk_en_reg, crc_check_capable_reg, gen_en_reg,
		crc_generate_capable_reg, first_error_pointer_reg}; // see RL12

	// word of the addressed register; unmapped offsets and reserved bits read zero
	always_comb begin
		rd_word = '0;
		case ({haddr[11:2], 2'b00})
			ofs_uncorr_severity: rd_word = severity_reg;
			ofs_corr_status: rd_word = correctable_error_status_reg;
			ofs_corr_mask: rd_word = correctable_error_mask_reg;
			ofs_adv_control: rd_word = control_word;
			ofs_uncorr_status: rd_word = uncorrectable_error_status_reg;
			ofs_uncorr_mask: rd_word = uncorrectable_error_mask_reg;
			ofs_irq_status: rd_word = {29'h0, irq_status_reg};
			ofs_irq_mask: rd_word = {29'h0, irq_mask_reg};
			ofs_lock: rd_word = {31'h0, lock_open_reg};
			default: rd_word = '0;
		endcase
	end

	// read data stands until the next read address phase is taken
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
		end else if (rd_take) begin
			hrdata <= rd_word;
		end
	end
endmodule

// ===== tb/aer_regs_asserts.sv
// checker: port properties of the error register bank
`timescale 1ns/1ps
module aer_regs_asserts
	import aer_regs_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic power_on_resetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic crc_error_event,
	input wire logic unsup_request_event,
	input wire logic report_nonfatal,
	input wire logic report_fatal,
	input wire logic crc_generate_enable,
	input wire logic crc_check_enable,
	input wire logic irq
);
	wire req = hsel && htrans == htrans_nonseq;
	wire unc = crc_error_event || unsup_request_event;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn || !power_on_resetn);
	sequence s_no_write;
		!(req && hwrite) ##1 1'b1;
	endsequence
	chk_ready_high: assert property (hreadyout) else $error("wait state seen");
	chk_resp_okay: assert property (!hresp) else $error("error response seen");
	chk_fatal_cause: assert property (report_fatal |-> $past(unc))
		else $error("fatal report without event");
	chk_nonfatal_cause: assert property (report_nonfatal |-> $past(unc))
		else $error("nonfatal report without event");
	chk_irq_fall: assert property ($fell(irq) |-> $past(req && hwrite, 2))
		else $error("irq dropped without write");
	chk_gen_hold: assert property (s_no_write |=> $stable(crc_generate_enable))
		else $error("generate enable moved");
	chk_check_hold: assert property (s_no_write |=> $stable(crc_check_enable))
		else $error("check enable moved");
	chk_rdata_hold: assert property (!(req && !hwrite) |=> $stable(hrdata))
		else $error("read data moved");
endmodule
bind pcie_advanced_error_regs aer_regs_asserts i_chk(.hclk(hclk), .hresetn(hresetn),
	.power_on_resetn(power_on_resetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .crc_error_event(crc_error_event),
	.unsup_request_event(unsup_request_event), .report_nonfatal(report_nonfatal),
	.report_fatal(report_fatal), .crc_generate_enable(crc_generate_enable),
	.crc_check_enable(crc_check_enable), .irq(irq));

// ===== tb/error_source_model.sv
// partner: raises error events and counts the reports sent upstream
`timescale 1ns/1ps
module error_source_model(
	input wire logic hclk,
	output logic [7:0] ev,
	input wire logic rep_c,
	input wire logic rep_n,
	input wire logic rep_f
);
	int n_c = 0, n_n = 0, n_f = 0;
	initial ev = 8'h00;
	task automatic pulse(input logic [7:0] m);
		@(posedge hclk);
		ev <= m;
		@(posedge hclk);
		ev <= 8'h00;
	endtask
	always @(posedge hclk) begin
		n_c <= n_c + int'(rep_c);
		n_n <= n_n + int'(rep_n);
		n_f <= n_f + int'(rep_f);
	end
endmodule

// ===== tb/pcie_advanced_error_regs_bench.sv
// bench: bus and event tests of the error register bank
`timescale 1ns/1ps
module pcie_advanced_error_regs_bench;
	import aer_regs_pkg::*;
	logic hclk = 0, hresetn = 0, por_n = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
	logic rc, rn, rf, gen, chk_en, irq;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = hsize_word, sz = hsize_word;
	logic [11:0] haddr = 12'h000;
	logic [31:0] hwdata = 32'h0, hrdata, q, e = 32'h0;
	logic [7:0] ev;
	int miscompares = 0, n_checks = 0;
	int pos[6] = '{0, 6, 7, 8, 12, 13};
	always #25 hclk = ~hclk;
	pcie_advanced_error_regs i_dut(.hclk(hclk), .hresetn(hresetn), .power_on_resetn(por_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .receiver_error_flag(ev[0]), .bad_packet_flag(ev[1]),
		.bad_link_packet_flag(ev[2]), .replay_rollover_flag(ev[3]),
		.replay_timeout_flag(ev[4]), .advisory_nonfatal_flag(ev[5]), .crc_error_event(ev[6]),
		.unsup_request_event(ev[7]), .report_correctable(rc), .report_nonfatal(rn),
		.report_fatal(rf), .crc_generate_enable(gen), .crc_check_enable(chk_en), .irq(irq));
	error_source_model i_src(.hclk(hclk), .ev(ev), .rep_c(rc), .rep_n(rn), .rep_f(rf));
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
		n_checks++;
		if (g !== x) begin
			$display("unexpected %s expected %h seen %h", s, x, g);
			miscompares++;
		end
	endtask
	task automatic wt;
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 16);
		if (hreadyout !== 1'b1) begin
			miscompares++;
			end_sim;
		end
	endtask
	task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= htrans_nonseq;
		hsize <= sz;
		wt;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wt;
		q = hrdata;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input string s);
		bus(a, 1'b0, 32'h0);
		chk(s, x, q);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask
	task automatic rst(input logic p);
		hresetn <= 1'b0;
		por_n <= p;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		por_n <= 1'b1;
	endtask
	initial begin
		rst(1'b0);
		rd(ofs_corr_mask, corr_mask_rst, "mask");
		rd(ofs_adv_control, 32'h000000A0, "control");
		rd(12'h1FC, 32'h0, "unmapped");
		for (int i = 0; i < 6; i++) begin
			i_src.pulse(8'h01 << i);
			e = e | (32'h1 << pos[i]);
			rd(ofs_corr_status, e, "status");
		end
		chk("reports", 5, i_src.n_c);
		wr(ofs_corr_status, corr_valid);
		rd(ofs_corr_status, 32'h0, "cleared");
		wr(ofs_corr_mask, corr_valid);
		i_src.pulse(8'h3F);
		rd(ofs_corr_status, corr_valid, "masked");
		chk("masked reports", 5, i_src.n_c);
		wr(ofs_corr_mask, 32'h0);
		i_src.pulse(8'h20);
		rd(ofs_corr_mask, 32'h0, "mask");
		chk("advisory", 6, i_src.n_c);
		sz = 3'h0;
		wr(ofs_corr_mask, corr_valid);
		sz = hsize_word;
		rd(ofs_corr_mask, 32'h0, "byte write ignored");
		$display("test correctable done");
		wr(ofs_uncorr_severity, 32'h00080000);
		i_src.pulse(8'h40);
		rd(ofs_adv_control, 32'h000000B3, "pointer");
		i_src.pulse(8'h80);
		rd(ofs_uncorr_status, 32'h00180000, "uncorr");
		chk("fatal", 1, i_src.n_f);
		chk("nonfatal", 1, i_src.n_n);
		wr(ofs_uncorr_status, 32'h00180000);
		wr(ofs_uncorr_mask, 32'h00080000);
		i_src.pulse(8'h40);
		rd(ofs_uncorr_status, 32'h0, "masked uncorr");
		chk("masked fatal", 1, i_src.n_f);
		rd(ofs_adv_control, 32'h000000A0, "pointer clear");
		wr(ofs_adv_control, 32'h00000140);
		rd(ofs_adv_control, 32'h000001E0, "enables");
		chk("enable pins", 3, {gen, chk_en});
		wr(ofs_lock, 32'h1);
		wr(ofs_adv_control, 32'h00000140);
		rd(ofs_adv_control, 32'h00000140, "locked");
		wr(ofs_lock, 32'h0);
		rst(1'b1);
		rd(ofs_adv_control, 32'h000001E0, "warm");
		rd(ofs_corr_status, corr_valid, "sticky");
		$display("test control done");
		wr(ofs_irq_status, 32'h7);
		wr(ofs_irq_mask, 32'h1);
		@(negedge hclk);
		chk("irq idle", 0, irq);
		i_src.pulse(8'h01);
		@(negedge hclk);
		chk("irq", 1, irq);
		wr(ofs_irq_status, 32'h1);
		@(negedge hclk);
		chk("irq clear", 0, irq);
		rst(1'b0);
		rd(ofs_corr_status, 32'h0, "power on");
		$display("test irq done");
		end_sim;
	end
endmodule
